// *** inc/ocs_params.svh ***
// constants of the otg_session_id_status and interrupt source block
// assumes a 10 mhz core clock and a byte-wide internal register port
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH

// register addresses
`define OCS_ADDR_INT_SRC     8'h08
`define OCS_ADDR_OTG_STAT    8'h10
`define OCS_ADDR_CK_DELAY    8'h1f

// reset value and unmapped read value
`define OCS_CK_DELAY_RST     8'hc8
`define OCS_RD_UNMAPPED      8'h00

// otg_session_id_status field positions
`define OCS_OTG_SESS_OVER    6
`define OCS_OTG_ACC_RES      3
`define OCS_OTG_CHG_HI_RES   2
`define OCS_OTG_CHG_MID_RES  1

// interrupt source field positions
`define OCS_INT_CK_STEREO    7
`define OCS_INT_DISC_PU      6
`define OCS_INT_ID_OPEN      5
`define OCS_INT_MINUS_HI     4
`define OCS_INT_ID_GROUNDED_FLAG       3
`define OCS_INT_PLUS_HI      2
`define OCS_INT_SESSION_VALID_FLAG     1
`define OCS_INT_SUPPLY_VLD   0

// synchroniser lane indices
`define OCS_IN_SESS_OVER     0
`define OCS_IN_ACC_RES       1
`define OCS_IN_CHG_HI_RES    2
`define OCS_IN_CHG_MID_RES   3
`define OCS_IN_CK_PIN_LOW    4
`define OCS_IN_DISC_PU_EN    5
`define OCS_IN_DISC_PU_ON    6
`define OCS_IN_ID_OPEN       7
`define OCS_IN_MINUS_HI      8
`define OCS_IN_PLUS_HI       9
`define OCS_IN_ID_GROUNDED_FLAG        10
`define OCS_IN_A_SESSION_VALID_FLAG    11
`define OCS_IN_B_SESSION_VALID_FLAG    12
`define OCS_IN_SUPPLY_VLD    13
`define OCS_IN_POWER_DOWN    14
`define OCS_IN_COUNT         15

// carkit qualification tick: 0.25 ms at a 100 ns clock period
`define OCS_TICK_NS          250000
`define OCS_CLK_PERIOD_NS    100
`define OCS_TICK_CYCLES      ((`OCS_TICK_NS) / (`OCS_CLK_PERIOD_NS))

`endif

// *** inc/ocs_pkg.sv ***
// types shared by the otg_session_id_status block and its carkit qualifier
// assumes ocs_params.svh holds the numeric constants
package ocs_pkg;

    typedef logic [7:0] ocs_byte_t;

    typedef enum logic [1:0] {
        OCS_Q_IDLE  = 2'b00,
        OCS_Q_COUNT = 2'b01,
        OCS_Q_HELD  = 2'b10
    } ocs_qual_state_t;

endpackage

// *** inc/ocs_qual_if.sv ***
// link between the status block and the carkit interrupt qualifier
// assumes both ends run on the same clock
interface ocs_qual_if;
    import ocs_pkg::*;

    logic      pin_low;
    ocs_byte_t delay;
    logic      stereo_event;

    modport owner (output pin_low, output delay, input stereo_event);
    modport qual  (input pin_low, input delay, output stereo_event);
endinterface

// *** rtl/ocs_carkit_qual.sv ***
// carkit interrupt qualifier: turns a synchronised comparator level
// into the stereo event, either directly or after a programmed delay
// assumes pin_low is already synchronised to clk_i
`include "ocs_params.svh"

module ocs_carkit_qual #(
    parameter int unsigned TICK_CYCLES = `OCS_TICK_CYCLES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // qualifier link
    ocs_qual_if.qual  q
);
    import ocs_pkg::*;

    localparam int unsigned PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    ocs_qual_state_t state;
    ocs_qual_state_t next_state;
    logic [PW-1:0]   presc;
    logic [PW-1:0]   next_presc;
    ocs_byte_t       ticks;
    ocs_byte_t       next_ticks;
    ocs_byte_t       ticks_inc;
    logic            ev;
    logic            next_ev;

    assign q.stereo_event = ev;

    always_comb begin
        next_state = state;
        next_presc = presc;
        next_ticks = ticks;
        next_ev    = 1'b0;
        ticks_inc  = 8'(ticks + 8'h01);
        if (q.delay == 8'h00) begin
            next_state = OCS_Q_IDLE;
            next_presc = '0;
            next_ticks = 8'h00;
            next_ev    = q.pin_low;
        end else begin
            case (state)
                OCS_Q_IDLE: begin
                    next_presc = '0;
                    next_ticks = 8'h00;
                    if (q.pin_low) begin
                        next_state = OCS_Q_COUNT;
                    end
                end
                OCS_Q_COUNT: begin
                    if (!q.pin_low) begin
                        next_state = OCS_Q_IDLE;
                    end else if (presc == PW'(TICK_CYCLES - 1)) begin
                        next_presc = '0;
                        next_ticks = ticks_inc;
                        if (ticks_inc >= q.delay) begin
                            next_state = OCS_Q_HELD;
                            next_ev    = 1'b1;
                        end
                    end else begin
                        next_presc = PW'(presc + 1'b1);
                    end
                end
                OCS_Q_HELD: begin
                    next_ev = q.pin_low;
                    if (!q.pin_low) begin
                        next_state = OCS_Q_IDLE;
                    end
                end
                default: begin
                    next_state = OCS_Q_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state <= OCS_Q_IDLE;
            presc <= '0;
            ticks <= 8'h00;
            ev    <= 1'b0;
        end else begin
            state <= next_state;
            presc <= next_presc;
            ticks <= next_ticks;
            ev    <= next_ev;
        end
    end

endmodule

// *** rtl/ocs_status_regs.sv ***
// otg_session_id_status and interrupt source registers with carkit qualification
// assumes the serial control slave presents decoded byte reads and
// writes on the register port, one cycle each, synchronous to clk_i
`include "ocs_params.svh"

// What this block does
// - session-over bit 6 follows the supply below session-end comparator.
// - power-down forces session-over, resistor bits and carkit bit to zero.
// - status bit 3 shows the 102 kilo-ohm accessory resistor.
// - status bit 2 shows the 440 kilo-ohm charger resistor.
// - status bit 1 shows the 200 kilo-ohm charger resistor.
// - otg_session_id_status is read-only at 10h; bits 7, 5, 4, 0 reserved.
// - interrupt source at 08h shows live unlatched condition levels.
// - zero delay drives bit 7 straight from the carkit comparator.
// - nonzero delay sets bit 7 after continuous low for the delay.
// - delay is eight bits of 0.25 ms ticks, reset c8h.
// - bit 6 shows auto pull-up after disconnect when enabled.
// - bit 5 is one while the id pin floats.
// - interrupt source bits are read-only; bit 6 resets to zero.
// - bit 4 follows the minus line receiver.
// - bit 3 shows id grounded, zero in power-down.
// - bit 1 shows session valid for the role picked by id grounded.
module ocs_status_regs #(
    parameter int unsigned TICK_CYCLES = `OCS_TICK_CYCLES
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // register port
    input  wire ocs_pkg::ocs_byte_t reg_addr_i,
    input  wire logic             reg_rd_i,
    input  wire logic             reg_wr_i,
    input  wire ocs_pkg::ocs_byte_t reg_wdata_i,
    output ocs_pkg::ocs_byte_t    reg_rdata_o,
    output logic                  reg_rvalid_o,
    // supply and id detectors
    input  wire logic             sess_over_det_i,
    input  wire logic             accessory_res_det_i,
    input  wire logic             charger_high_res_det_i,
    input  wire logic             charger_mid_res_det_i,
    input  wire logic             id_open_det_i,
    input  wire logic             id_grounded_det_i,
    input  wire logic             a_sess_valid_det_i,
    input  wire logic             b_sess_valid_det_i,
    input  wire logic             supply_valid_det_i,
    // line receivers and carkit comparator
    input  wire logic             minus_line_high_i,
    input  wire logic             plus_line_high_i,
    input  wire logic             carkit_irq_pin_low_i,
    // pull-up sequencer and mode
    input  wire logic             disconnect_pullup_auto_enable_i,
    input  wire logic             disconnect_pullup_on_i,
    input  wire logic             power_down_i,
    // live register images
    output ocs_pkg::ocs_byte_t    otg_session_id_status_o,
    output ocs_pkg::ocs_byte_t    interrupt_condition_state_o
);
    import ocs_pkg::*;

    localparam int unsigned NS = `OCS_IN_COUNT;

    logic [NS-1:0] raw;
    logic [NS-1:0] sync1;
    logic [NS-1:0] next_sync1;
    logic [NS-1:0] s;
    logic [NS-1:0] next_s;

    ocs_byte_t otg_stat;
    ocs_byte_t next_otg_stat;
    ocs_byte_t int_src;
    ocs_byte_t next_int_src;
    ocs_byte_t ck_delay;
    ocs_byte_t next_ck_delay;
    ocs_byte_t rdata;
    ocs_byte_t next_rdata;
    logic      rvalid;
    logic      next_rvalid;
    logic      pd;

    ocs_qual_if qif ();

    assign raw[`OCS_IN_SESS_OVER]   = sess_over_det_i;
    assign raw[`OCS_IN_ACC_RES]     = accessory_res_det_i;
    assign raw[`OCS_IN_CHG_HI_RES]  = charger_high_res_det_i;
    assign raw[`OCS_IN_CHG_MID_RES] = charger_mid_res_det_i;
    assign raw[`OCS_IN_CK_PIN_LOW]  = carkit_irq_pin_low_i;
    assign raw[`OCS_IN_DISC_PU_EN]  = disconnect_pullup_auto_enable_i;
    assign raw[`OCS_IN_DISC_PU_ON]  = disconnect_pullup_on_i;
    assign raw[`OCS_IN_ID_OPEN]     = id_open_det_i;
    assign raw[`OCS_IN_MINUS_HI]    = minus_line_high_i;
    assign raw[`OCS_IN_PLUS_HI]     = plus_line_high_i;
    assign raw[`OCS_IN_ID_GROUNDED_FLAG]      = id_grounded_det_i;
    assign raw[`OCS_IN_A_SESSION_VALID_FLAG]  = a_sess_valid_det_i;
    assign raw[`OCS_IN_B_SESSION_VALID_FLAG]  = b_sess_valid_det_i;
    assign raw[`OCS_IN_SUPPLY_VLD]  = supply_valid_det_i;
    assign raw[`OCS_IN_POWER_DOWN]  = power_down_i;

    always_comb begin
        next_sync1 = raw;
        next_s     = sync1;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sync1 <= '0;
            s     <= '0;
        end else begin
            sync1 <= next_sync1;
            s     <= next_s;
        end
    end

    assign pd          = s[`OCS_IN_POWER_DOWN];
    assign qif.pin_low = s[`OCS_IN_CK_PIN_LOW];
    assign qif.delay   = ck_delay;

    ocs_carkit_qual #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_qual (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .q         (qif.qual)
    );

    // status images, rebuilt every cycle from the synchronised levels
    always_comb begin
        next_otg_stat = 8'h00;
        next_int_src  = 8'h00;
        next_otg_stat[`OCS_OTG_SESS_OVER]   = s[`OCS_IN_SESS_OVER] & ~pd;
        next_otg_stat[`OCS_OTG_ACC_RES]     = s[`OCS_IN_ACC_RES] & ~pd;
        next_otg_stat[`OCS_OTG_CHG_HI_RES]  = s[`OCS_IN_CHG_HI_RES] & ~pd;
        next_otg_stat[`OCS_OTG_CHG_MID_RES] = s[`OCS_IN_CHG_MID_RES] & ~pd;
        // power-down gating of the carkit event
        next_int_src[`OCS_INT_CK_STEREO]    = qif.stereo_event & ~pd;
        next_int_src[`OCS_INT_DISC_PU]      = s[`OCS_IN_DISC_PU_EN] & s[`OCS_IN_DISC_PU_ON];
        next_int_src[`OCS_INT_ID_OPEN]      = s[`OCS_IN_ID_OPEN];
        next_int_src[`OCS_INT_MINUS_HI]     = s[`OCS_IN_MINUS_HI];
        next_int_src[`OCS_INT_ID_GROUNDED_FLAG]       = s[`OCS_IN_ID_GROUNDED_FLAG] & ~pd;
        next_int_src[`OCS_INT_PLUS_HI]      = s[`OCS_IN_PLUS_HI];
        next_int_src[`OCS_INT_SESSION_VALID_FLAG]     = s[`OCS_IN_ID_GROUNDED_FLAG] ? s[`OCS_IN_A_SESSION_VALID_FLAG]
                                                                : s[`OCS_IN_B_SESSION_VALID_FLAG];
        // b-device role reuses bit 0 as the session-over detector
        next_int_src[`OCS_INT_SUPPLY_VLD]   = s[`OCS_IN_ID_GROUNDED_FLAG] ? s[`OCS_IN_SUPPLY_VLD]
                                                                : s[`OCS_IN_SESS_OVER];
    end

    // register port: only the delay register takes writes
    always_comb begin
        next_ck_delay = ck_delay;
        next_rdata    = rdata;
        next_rvalid   = reg_rd_i;
        if (reg_wr_i && (reg_addr_i == `OCS_ADDR_CK_DELAY)) begin
            next_ck_delay = reg_wdata_i;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `OCS_ADDR_INT_SRC:  next_rdata = int_src;
                `OCS_ADDR_OTG_STAT: next_rdata = otg_stat;
                `OCS_ADDR_CK_DELAY: next_rdata = ck_delay;
                default:            next_rdata = `OCS_RD_UNMAPPED;
            endcase
        end
    end

    // images reset to zero, then follow the pins
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            otg_stat <= 8'h00;
            int_src  <= 8'h00;
            ck_delay <= `OCS_CK_DELAY_RST;
            rdata    <= 8'h00;
            rvalid   <= 1'b0;
        end else begin
            otg_stat <= next_otg_stat;
            int_src  <= next_int_src;
            ck_delay <= next_ck_delay;
            rdata    <= next_rdata;
            rvalid   <= next_rvalid;
        end
    end

    assign reg_rdata_o                 = rdata;
    assign reg_rvalid_o                = rvalid;
    assign otg_session_id_status_o     = otg_stat;
    assign interrupt_condition_state_o = int_src;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // helper: consecutive qualified-low cycles with a nonzero delay outside power-down
    logic [31:0] low_run;
    logic [31:0] low_lim;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            low_run <= 32'h0;
        end else if (qif.pin_low && !pd && ck_delay != 8'h00
                     && ck_delay == qif.delay && low_run != 32'hffff_ffff) begin
            low_run <= low_run + 32'h1;
        end else begin
            low_run <= 32'h0;
        end
    end

    assign low_lim = 32'(ck_delay) * 32'(TICK_CYCLES) + 32'h2;

    chk_sess_over_level:
        assert property (s[`OCS_IN_SESS_OVER] && !pd |=> otg_stat[`OCS_OTG_SESS_OVER])
        else $error("session-over bit missed the comparator");

    chk_pd_forces_zero:
        assert property (pd |=> otg_stat[`OCS_OTG_SESS_OVER] == 1'b0
                         && otg_stat[`OCS_OTG_ACC_RES:`OCS_OTG_CHG_MID_RES] == 3'h0
                         && int_src[`OCS_INT_CK_STEREO] == 1'b0
                         && int_src[`OCS_INT_ID_GROUNDED_FLAG] == 1'b0)
        else $error("power-down left a status bit set");

    chk_resistor_bits:
        assert property (otg_stat[`OCS_OTG_ACC_RES:`OCS_OTG_CHG_MID_RES]
                         == $past({s[`OCS_IN_ACC_RES], s[`OCS_IN_CHG_HI_RES],
                                   s[`OCS_IN_CHG_MID_RES]} & {3{!pd}}))
        else $error("id resistor bits disagree with detectors");

    chk_reserved_zero:
        assert property (otg_stat[7] == 1'b0 && otg_stat[5:4] == 2'h0 && otg_stat[0] == 1'b0)
        else $error("reserved status bit set");

    chk_read_mux:
        assert property (reg_rd_i && reg_addr_i == `OCS_ADDR_INT_SRC
                         |=> reg_rvalid_o && reg_rdata_o == $past(int_src))
        else $error("interrupt source read returned wrong byte");

    chk_direct_carkit:
        assert property (ck_delay == 8'h00 && qif.pin_low && !pd
                         ##1 ck_delay == 8'h00 && qif.pin_low && !pd
                         |=> int_src[`OCS_INT_CK_STEREO])
        else $error("direct carkit bit not set");

    chk_qual_fires:
        assert property (low_run >= low_lim |-> int_src[`OCS_INT_CK_STEREO])
        else $error("qualified carkit event missing after delay");

    chk_qual_no_early:
        assert property ($rose(qif.pin_low) && ck_delay != 8'h00
                         && !int_src[`OCS_INT_CK_STEREO]
                         |=> !int_src[`OCS_INT_CK_STEREO] [*2])
        else $error("carkit event before the delay ran");

    chk_delay_write:
        assert property (reg_wr_i && reg_addr_i == `OCS_ADDR_CK_DELAY
                         |=> ck_delay == $past(reg_wdata_i))
        else $error("delay register did not take the write");

    chk_pullup_event:
        assert property (int_src[`OCS_INT_DISC_PU]
                         == $past(s[`OCS_IN_DISC_PU_EN] && s[`OCS_IN_DISC_PU_ON]))
        else $error("pull-up event bit wrong");

    chk_id_open:
        assert property (s[`OCS_IN_ID_OPEN] ##1 s[`OCS_IN_ID_OPEN]
                         |=> int_src[`OCS_INT_ID_OPEN] [*1])
        else $error("floating id not shown");

    chk_reset_bit6:
        assert property (!$past(reset_n_i) |-> int_src[`OCS_INT_DISC_PU] == 1'b0)
        else $error("pull-up event bit not clear after reset");

    chk_minus_line:
        assert property (int_src[`OCS_INT_MINUS_HI] == $past(s[`OCS_IN_MINUS_HI]))
        else $error("minus line bit wrong");

    chk_role_session:
        assert property (int_src[`OCS_INT_SESSION_VALID_FLAG]
                         == $past(s[`OCS_IN_ID_GROUNDED_FLAG] ? s[`OCS_IN_A_SESSION_VALID_FLAG]
                                                    : s[`OCS_IN_B_SESSION_VALID_FLAG]))
        else $error("session valid bit ignores the role");

    chk_ro_write:
        assert property (reg_wr_i && reg_addr_i != `OCS_ADDR_CK_DELAY |=> $stable(ck_delay))
        else $error("write to a read-only address changed state");

    cov_qual_event:
        cover property (ck_delay != 8'h00 && $rose(int_src[`OCS_INT_CK_STEREO]));

    cov_direct_event:
        cover property (ck_delay == 8'h00 && $rose(int_src[`OCS_INT_CK_STEREO]));

    cov_status_read:
        cover property (reg_rd_i && reg_addr_i == `OCS_ADDR_OTG_STAT ##1 reg_rdata_o != 8'h00);

    cov_power_down:
        cover property ($rose(pd) ##2 otg_stat == 8'h00);

endmodule

// *** rtl/ocs_status_regs_dummy_guard.sv ***
// this file holds no logic

// *** tb/ocs_host_model.sv ***
// host side of the register port: byte reads and writes, one at a time
// assumes the block answers a read with a one-cycle strobe after it is taken
module ocs_host_model (
    // clock
    input  wire logic               clk_i,
    // register port
    output ocs_pkg::ocs_byte_t      reg_addr_o,
    output logic                    reg_rd_o,
    output logic                    reg_wr_o,
    output ocs_pkg::ocs_byte_t      reg_wdata_o,
    input  wire ocs_pkg::ocs_byte_t reg_rdata_i,
    input  wire logic               reg_rvalid_i
);
    timeunit 1ns;
    timeprecision 100ps;
    import ocs_pkg::*;

    initial begin
        reg_addr_o  = 8'h00;
        reg_rd_o    = 1'b0;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // idle address and data are inverted so a stale value never looks valid
    task automatic wr(input ocs_byte_t a, input ocs_byte_t d);
        @(posedge clk_i);
        #1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(posedge clk_i);
        #1;
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask

    task automatic rd(input ocs_byte_t a, output ocs_byte_t d, output logic ok);
        int n;
        ok = 1'b0;
        d  = 8'h00;
        @(posedge clk_i);
        #1;
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(posedge clk_i);
        #1;
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a;
        for (n = 0; n < 4 && ok !== 1'b1; n++) begin
            if (reg_rvalid_i === 1'b1) begin
                ok = 1'b1;
                d  = reg_rdata_i;
            end else begin
                @(posedge clk_i);
                #1;
            end
        end
    endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the otg_session_id_status and interrupt source registers
// assumes a shortened qualification tick so the carkit delay stays short
`include "ocs_params.svh"

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ocs_pkg::*;

    localparam int TK  = 4;
    localparam int DLY = 2;
    // two sync flops, qualified low count, idle detect and image flop
    localparam int EXP = 2 + DLY * TK + 2;

    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [12:0] det = 13'h0000;
    logic        ck_low = 1'b0;
    logic        pd = 1'b0;
    ocs_byte_t   addr;
    ocs_byte_t   wdata;
    ocs_byte_t   rdata;
    ocs_byte_t   img_otg;
    ocs_byte_t   img_int;
    logic        rd;
    logic        wr;
    logic        rvalid;
    int          failures = 0;
    int          n_tests = 0;
    int          j;
    int          n;

    always #50 clk = ~clk;

    ocs_host_model host (.clk_i(clk), .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

    ocs_status_regs #(.TICK_CYCLES(TK)) DUT (
        .clk_i(clk), .reset_n_i(reset_n),
        .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .sess_over_det_i(det[0]), .accessory_res_det_i(det[1]),
        .charger_high_res_det_i(det[2]), .charger_mid_res_det_i(det[3]),
        .id_open_det_i(det[4]), .id_grounded_det_i(det[5]),
        .a_sess_valid_det_i(det[6]), .b_sess_valid_det_i(det[7]),
        .supply_valid_det_i(det[8]), .minus_line_high_i(det[9]),
        .plus_line_high_i(det[10]), .carkit_irq_pin_low_i(ck_low),
        .disconnect_pullup_auto_enable_i(det[11]), .disconnect_pullup_on_i(det[12]),
        .power_down_i(pd),
        .otg_session_id_status_o(img_otg), .interrupt_condition_state_o(img_int));

    // role picks the session-valid source; power-down clears bits 7 and 3 only
    function automatic ocs_byte_t exp_int(logic [12:0] v, logic ck, logic p);
        return {ck & ~p, v[11] & v[12], v[4], v[9], v[5] & ~p, v[10],
                v[5] ? v[6] : v[7], v[5] ? v[8] : v[0]};
    endfunction

    function automatic ocs_byte_t exp_otg(logic [12:0] v, logic p);
        return p ? 8'h00 : {1'b0, v[0], 2'b00, v[1], v[2], v[3], 1'b0};
    endfunction

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input ocs_byte_t seen, input ocs_byte_t exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a missing answer ends the run at once
    task automatic rd_chk(input ocs_byte_t a, input ocs_byte_t exp);
        ocs_byte_t d;
        logic      ok;
        host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t no read answer", $time);
            report_and_stop();
        end else begin
            check(d, exp);
        end
    endtask

    initial begin
        det[12:11] = 2'b11;
        tick(5);
        check(img_int, 8'h00);
        reset_n = 1'b1;
        rd_chk(`OCS_ADDR_CK_DELAY, `OCS_CK_DELAY_RST);
        rd_chk(8'h20, `OCS_RD_UNMAPPED);
        // every detector combination, both registers
        for (j = 0; j < 8192; j++) begin
            tick(1);
            det = j[12:0];
            tick(2);
            rd_chk(`OCS_ADDR_INT_SRC, exp_int(det, 1'b0, 1'b0));
            rd_chk(`OCS_ADDR_OTG_STAT, exp_otg(det, 1'b0));
            check(img_otg, exp_otg(det, 1'b0));
        end
        host.wr(`OCS_ADDR_INT_SRC, 8'hff);
        host.wr(`OCS_ADDR_OTG_STAT, 8'h00);
        rd_chk(`OCS_ADDR_INT_SRC, exp_int(det, 1'b0, 1'b0));
        rd_chk(`OCS_ADDR_OTG_STAT, exp_otg(det, 1'b0));
        rd_chk(`OCS_ADDR_CK_DELAY, `OCS_CK_DELAY_RST);
        // power-down with every detector and the carkit pin active
        host.wr(`OCS_ADDR_CK_DELAY, 8'h00);
        det = 13'h1fff;
        ck_low = 1'b1;
        pd = 1'b1;
        tick(5);
        rd_chk(`OCS_ADDR_OTG_STAT, 8'h00);
        check(img_otg, 8'h00);
        rd_chk(`OCS_ADDR_INT_SRC, exp_int(det, 1'b1, 1'b1));
        pd = 1'b0;
        tick(5);
        rd_chk(`OCS_ADDR_INT_SRC, exp_int(det, 1'b1, 1'b0));
        ck_low = 1'b0;
        tick(5);
        rd_chk(`OCS_ADDR_INT_SRC, exp_int(det, 1'b0, 1'b0));
        // qualified mode: a short low must not count, the restart must
        host.wr(`OCS_ADDR_CK_DELAY, DLY[7:0]);
        rd_chk(`OCS_ADDR_CK_DELAY, DLY[7:0]);
        tick(1);
        ck_low = 1'b1;
        tick(6);
        ck_low = 1'b0;
        tick(2);
        check({7'h00, img_int[7]}, 8'h00);
        ck_low = 1'b1;
        for (n = 0; n < 40 && img_int[7] !== 1'b1; n++) begin
            tick(1);
        end
        check(8'(n), 8'(EXP));
        if (n >= 40) begin
            report_and_stop();
        end
        rd_chk(`OCS_ADDR_INT_SRC, exp_int(det, 1'b1, 1'b0));
        ck_low = 1'b0;
        tick(6);
        rd_chk(`OCS_ADDR_INT_SRC, exp_int(det, 1'b0, 1'b0));
        report_and_stop();
    end
endmodule
